// [logic/rtp_pit.sv]
// compare value register and periodic interrupt timer with avalon slave
`timescale 1ns/1ps
// How it works
// - compare value is two bytes: low at base index, high at base plus one
// - control bits 6:3 pick 4 to 32768 rtc ticks; zero and reserved give none
// - control bit 0 turns the periodic timer on or off
// - sync status bit 0 reads one while control is moving to the rtc side
// - enable bit 0 lets the periodic flag raise the request
// - periodic flag sets each time the chosen interval elapses
// - writing one to the periodic flag clears it
// - halted cpu with debug-run clear freezes the timer and drops events
// - debug-run set keeps the timer going while the cpu is halted
// - one shared byte latch makes 16-bit accesses coherent
// - two-bit selector picks the rtc tick source, codes zero to three
module rtp_pit
  import rtp_pkg::*;
#(
  parameter int unsigned DIV_32K_CYC = DIV_32K,
  parameter int unsigned DIV_1K_CYC  = DIV_1K
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  // rtc clock pins
  input  wire logic        xtal_clk_in,
  input  wire logic        ext_clk_in,
  // debug halt from the cpu, same clock
  input  wire logic        cpu_halted_in,
  // to the rtc counter comparison and interrupt controller
  output logic [15:0]      compare_value_out,
  output logic             pit_irq_out,
  output logic             irq_out
);

  // register state
  logic [15:0]       compare_value;
  logic [7:0]        staging_byte;
  logic [7:0]        periodic_timer_control;
  logic [7:0]        active_control;
  logic [1:0]        sync_left;
  logic              periodic_irq_enable;
  logic              periodic_irq;
  logic              run_while_halted;
  logic [1:0]        rtc_source_select;
  logic [EVT_W-1:0]  evt_status;
  logic [EVT_W-1:0]  evt_mask;
  logic [15:0]       tick_count;
  logic              rtc_tick;

  // bus decode
  wire        bus_req   = read_in | write_in;
  wire        bus_take  = bus_req & ~waitrequest_out;
  wire        bus_wr    = write_in & bus_take;
  wire        bus_rd    = read_in & bus_take;
  wire        aligned   = (address_in[1:0] == 2'b00);
  wire [5:0]  bus_idx   = address_in[7:2];
  wire [7:0]  wbyte     = writedata_in[7:0];
  wire        sel_src   = aligned & (bus_idx == IDX_SRC_SEL);
  wire        sel_cmp_l = aligned & (bus_idx == IDX_CMP_LO);
  wire        sel_cmp_h = aligned & (bus_idx == IDX_CMP_HI);
  wire        sel_ctrl  = aligned & (bus_idx == IDX_CTRL);
  wire        sel_sync  = aligned & (bus_idx == IDX_SYNC);
  wire        sel_ien   = aligned & (bus_idx == IDX_IEN);
  wire        sel_iflag = aligned & (bus_idx == IDX_IFLAG);
  wire        sel_dbg   = aligned & (bus_idx == IDX_DBG);
  wire        sel_stat  = aligned & (bus_idx == IDX_EVT_STAT);
  wire        sel_mask  = aligned & (bus_idx == IDX_EVT_MASK);

  // sync status shows pending transfer of control into the rtc side
  wire        ctrl_busy = (sync_left != 2'h0);

  // read data select; unmapped addresses read as zero
  wire [7:0]  rd_byte =
    sel_src   ? {6'h00, rtc_source_select} :
    sel_cmp_l ? compare_value[7:0] :
    sel_cmp_h ? staging_byte :
    sel_ctrl  ? periodic_timer_control :
    sel_sync  ? {7'h00, ctrl_busy} :
    sel_ien   ? {7'h00, periodic_irq_enable} :
    sel_iflag ? {7'h00, periodic_irq} :
    sel_dbg   ? {7'h00, run_while_halted} :
    sel_stat  ? {{(8-EVT_W){1'b0}}, evt_status} :
    sel_mask  ? {{(8-EVT_W){1'b0}}, evt_mask} : 8'h00;

  // rtc tick source
  rtp_tick_gen #(
    .DIV_32K_CYC (DIV_32K_CYC),
    .DIV_1K_CYC  (DIV_1K_CYC)
  ) u_tick (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .src_sel_in  (rtc_source_select),
    .xtal_clk_in (xtal_clk_in),
    .ext_clk_in  (ext_clk_in),
    .tick_out    (rtc_tick)
  );

  // timer only sees ticks while not frozen by a debug halt
  wire        timer_runs = ~cpu_halted_in | run_while_halted;
  wire        tick_ok    = rtc_tick & timer_runs;
  wire        timer_on   = active_control[CTRL_ON_BIT];
  wire [3:0]  period_code = active_control[CTRL_PER_MSB:CTRL_PER_LSB];
  wire        period_ok  = (period_code != PER_OFF) & (period_code != PER_RSVD);
  // interval is 2^(code+1) ticks: event when the low code+1 count bits are all ones
  wire [16:0] period_wide = (17'h00001 << (period_code + 4'h1)) - 17'h00001;
  wire [15:0] period_mask = period_wide[15:0];
  wire        interval_hit = ((tick_count & period_mask) == period_mask);
  wire        pit_event  = tick_ok & timer_on & period_ok & interval_hit;

  // control transfer finishes on an rtc tick; a new write restarts it
  wire        ctrl_write = bus_wr & sel_ctrl;
  wire        sync_step  = rtc_tick & ctrl_busy & ~ctrl_write;
  wire        sync_done  = sync_step & (sync_left == 2'h1);
  wire [1:0]  next_sync_left = ctrl_write ? SYNC_TICKS :
                               sync_step  ? sync_left - 2'h1 : sync_left;

  // flag sets on the interval; a set in the clearing cycle wins
  wire        flag_clear = bus_wr & sel_iflag & wbyte[0];
  wire        next_periodic_irq = pit_event | (periodic_irq & ~flag_clear);

  // sticky event status, cleared by reading it; new events win
  wire [EVT_W-1:0] evt_now;
  assign evt_now[EVT_PERIODIC] = pit_event;
  assign evt_now[EVT_SYNCED]   = sync_done;
  wire [EVT_W-1:0] next_evt_status = evt_now |
                                     (evt_status & ~{EVT_W{bus_rd & sel_stat}});

  // bus handshake: waitrequest drops one cycle after a request appears,
  // read data are loaded in that same cycle and the access commits on take
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      waitrequest_out <= 1'b1;
      readdata_out    <= 32'h00000000;
    end else begin
      waitrequest_out <= ~(bus_req & waitrequest_out);
      if (bus_req & waitrequest_out) begin
        readdata_out <= {24'h000000, rd_byte};
      end
    end
  end

  // compare value through the shared staging byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_value <= CMP_RST;
      staging_byte  <= 8'h00;
    end else if (bus_wr & sel_cmp_l) begin
      staging_byte <= wbyte;
    end else if (bus_wr & sel_cmp_h) begin
      compare_value <= {wbyte, staging_byte};
    end else if (bus_rd & sel_cmp_l) begin
      staging_byte <= compare_value[15:8];
    end
  end

  // software control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      periodic_timer_control <= CTRL_RST;
      periodic_irq_enable    <= 1'b0;
      run_while_halted       <= 1'b0;
      rtc_source_select      <= SRC_RST;
      evt_mask               <= '0;
    end else if (bus_wr) begin
      if (sel_ctrl)
        periodic_timer_control <= wbyte & CTRL_WMASK;
      if (sel_ien)
        periodic_irq_enable <= wbyte[0];
      if (sel_dbg)
        run_while_halted <= wbyte[0];
      if (sel_src)
        rtc_source_select <= wbyte[1:0];
      if (sel_mask)
        evt_mask <= wbyte[EVT_W-1:0];
    end
  end

  // rtc-side copy of control and its transfer count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_left      <= 2'h0;
      active_control <= CTRL_RST;
    end else begin
      sync_left <= next_sync_left;
      if (sync_done)
        active_control <= periodic_timer_control;
    end
  end

  // interval counter restarts whenever the timer is off
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_count <= 16'h0000;
    end else if (!timer_on) begin
      tick_count <= 16'h0000;
    end else if (tick_ok) begin
      tick_count <= tick_count + 16'h0001;
    end
  end

  // flags and interrupt outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      periodic_irq      <= 1'b0;
      evt_status        <= '0;
      pit_irq_out       <= 1'b0;
      irq_out           <= 1'b0;
      compare_value_out <= CMP_RST;
    end else begin
      periodic_irq      <= next_periodic_irq;
      evt_status        <= next_evt_status;
      pit_irq_out       <= periodic_irq & periodic_irq_enable;
      irq_out           <= |(evt_status & evt_mask);
      compare_value_out <= compare_value;
    end
  end

endmodule

// [inc/rtp_pkg.sv]
// shared constants for the periodic interrupt timer and compare register block
package rtp_pkg;

  // clock figures
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned OSC32K_HZ  = 32768;
  localparam int unsigned OSC1K_HZ   = 1024;
  // longest tick spacing rounds down to whole clock cycles
  localparam int unsigned DIV_32K    = CLK_HZ / OSC32K_HZ;
  localparam int unsigned DIV_1K     = CLK_HZ / OSC1K_HZ;
  localparam int unsigned DIV_W      = 18;

  // register indexes; the bus byte address is four times the index
  localparam logic [5:0] IDX_SRC_SEL  = 6'h07;
  localparam logic [5:0] IDX_CMP_LO   = 6'h0c;
  localparam logic [5:0] IDX_CMP_HI   = 6'h0d;
  localparam logic [5:0] IDX_CTRL     = 6'h10;
  localparam logic [5:0] IDX_SYNC     = 6'h11;
  localparam logic [5:0] IDX_IEN      = 6'h12;
  localparam logic [5:0] IDX_IFLAG    = 6'h13;
  localparam logic [5:0] IDX_DBG      = 6'h15;
  localparam logic [5:0] IDX_EVT_STAT = 6'h18;
  localparam logic [5:0] IDX_EVT_MASK = 6'h19;

  // field layout of the timer control register
  localparam int unsigned CTRL_ON_BIT  = 0;
  localparam int unsigned CTRL_PER_LSB = 3;
  localparam int unsigned CTRL_PER_MSB = 6;
  localparam logic [7:0]  CTRL_WMASK   = 8'h79;
  localparam logic [3:0]  PER_OFF      = 4'h0;
  localparam logic [3:0]  PER_RSVD     = 4'hf;

  // reset values
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [1:0]  SRC_RST  = 2'h0;

  // control value crosses into the rtc side after this many rtc ticks
  localparam logic [1:0]  SYNC_TICKS = 2'h2;

  // clock source codes
  localparam logic [1:0]  SRC_INT32K = 2'h0;
  localparam logic [1:0]  SRC_INT1K  = 2'h1;
  localparam logic [1:0]  SRC_XTAL   = 2'h2;
  localparam logic [1:0]  SRC_EXTPIN = 2'h3;

  // event status bits
  localparam int unsigned EVT_PERIODIC = 0;
  localparam int unsigned EVT_SYNCED   = 1;
  localparam int unsigned EVT_W        = 2;

endpackage

// [logic/rtp_tick_gen.sv]
// rtc tick enable generator: internal dividers or synchronised clock pins
`timescale 1ns/1ps
module rtp_tick_gen
  import rtp_pkg::*;
#(
  parameter int unsigned DIV_32K_CYC = DIV_32K,
  parameter int unsigned DIV_1K_CYC  = DIV_1K
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // source choice and pins
  input  wire logic [1:0] src_sel_in,
  input  wire logic       xtal_clk_in,
  input  wire logic       ext_clk_in,
  // one-cycle rtc tick
  output logic            tick_out
);

  logic [1:0]       pin_meta;
  logic [1:0]       pin_sync;
  logic [1:0]       pin_last;
  logic [DIV_W-1:0] div_cnt;
  wire  [1:0]       pin_raw = {ext_clk_in, xtal_clk_in};
  wire  [1:0]       pin_rise = pin_sync & ~pin_last;
  wire  [DIV_W-1:0] div_limit = (src_sel_in == SRC_INT1K) ?
                                DIV_W'(DIV_1K_CYC - 1) : DIV_W'(DIV_32K_CYC - 1);
  wire              div_wrap = (div_cnt >= div_limit);
  wire              next_tick = (src_sel_in == SRC_XTAL)   ? pin_rise[0] :
                                (src_sel_in == SRC_EXTPIN) ? pin_rise[1] : div_wrap;

  // each clock pin passes two flops, then a third for the edge
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
          pin_last[g] <= 1'b0;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
          pin_last[g] <= pin_sync[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt  <= '0;
      tick_out <= 1'b0;
    end else begin
      div_cnt  <= div_wrap ? '0 : div_cnt + 1'b1;
      tick_out <= next_tick;
    end
  end

endmodule

// [sim/rtp_pit_properties.sv]
// concurrent checks on the ports of the periodic timer register block
`timescale 1ns/1ps
module rtp_pit_properties
  import rtp_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // avalon-mm slave
  input wire logic [7:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  // outputs to the rtc and interrupt controller
  input wire logic [15:0] compare_value_out,
  input wire logic        pit_irq_out,
  input wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire done_wr = write_in && !waitrequest_out;
  wire hi_wr   = done_wr && (address_in == {IDX_CMP_HI, 2'h0});
  a_wait_single: assert property ($fell(waitrequest_out) |=> waitrequest_out)
    else $error("waitrequest held low too long");
  a_wait_answer: assert property ($rose(read_in || write_in) |=> !waitrequest_out)
    else $error("access not answered on the next edge");
  a_wait_idle: assert property (!(read_in || write_in) |=> waitrequest_out)
    else $error("answer without a request");
  a_upper_zero: assert property (!waitrequest_out |-> readdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_read: assert property (read_in && !waitrequest_out && address_in[1:0] != 2'h0
    |-> readdata_out == 32'h0) else $error("misaligned read not zero");
  a_cmp_load: assert property (hi_wr |=> ##1
    compare_value_out[15:8] == $past(writedata_in[7:0], 2))
    else $error("compare high byte not loaded");
  a_cmp_hold: assert property ($changed(compare_value_out) |-> $past(hi_wr, 2))
    else $error("compare changed without high write");
  a_flag_clear: assert property (done_wr && address_in == {IDX_IFLAG, 2'h0}
    && writedata_in[0] |=> ##1 !pit_irq_out) else $error("flag not cleared by one");
  a_enable_off: assert property (done_wr && address_in == {IDX_IEN, 2'h0}
    && !writedata_in[0] |=> ##1 !pit_irq_out) else $error("request not blocked");
  c_flag_read: cover property (read_in && !waitrequest_out && address_in == {IDX_IFLAG, 2'h0});
  c_pit_irq: cover property ($rose(pit_irq_out));
  c_irq: cover property ($rose(irq_out));
endmodule

bind rtp_pit rtp_pit_properties u_rtp_pit_properties (
  .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .compare_value_out(compare_value_out),
  .pit_irq_out(pit_irq_out), .irq_out(irq_out));

// [sim/tb_rtp_pit.sv]
// self-checking bench for the periodic timer register block
`timescale 1ns/1ps
module tb_rtp_pit;
  import rtp_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  address_in = 8'h0;
  logic        read_in = 1'b0;
  logic        write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic        xtal_clk_in = 1'b0;
  logic        ext_clk_in = 1'b0;
  logic        cpu_halted_in = 1'b0;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic [15:0] compare_value_out;
  logic        pit_irq_out;
  logic        irq_out;
  int          err_count = 0;
  int          checked = 0;
  int          seed = 32'h322e;
  int          cyc = 0;
  int          s, c, p;
  logic [31:0] v;
  logic [7:0]  rst_addr [10] = '{8'h1c, 8'h30, 8'h34, 8'h40, 8'h44,
                                 8'h48, 8'h4c, 8'h54, 8'h60, 8'h64};
  // software never writes the reserved period code, so bit 7 and 2:1 test the mask
  logic [7:0]  ctrl_val [2] = '{8'hf7, 8'h01};
  // short dividers keep every interval the period loop measures to a few hundred clocks
  rtp_pit #(.DIV_32K_CYC(8), .DIV_1K_CYC(16)) u_rtp_pit (
    .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .xtal_clk_in(xtal_clk_in), .ext_clk_in(ext_clk_in),
    .cpu_halted_in(cpu_halted_in), .compare_value_out(compare_value_out),
    .pit_irq_out(pit_irq_out), .irq_out(irq_out));
  always #2 clk_in = ~clk_in;
  // pin clocks rise every 10 and 14 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) xtal_clk_in <= ~xtal_clk_in;
    if (cyc % 7 == 6) ext_clk_in <= ~ext_clk_in;
  end
  function automatic int exp_period(input int src, input int code);
    int sp[4] = '{8, 16, 10, 14};
    return (1 << (code + 1)) * sp[src];
  endfunction
  task automatic summarize;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    summarize;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk_in);
    address_in <= a;
    read_in <= !wr;
    write_in <= wr;
    writedata_in <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) hang;
    q = readdata_out[7:0];
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h0, q);
    chk({24'h0, q}, {24'h0, e});
  endtask
  task automatic sync_wait;
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h44, 8'h0, q);
      n++;
    end while (q !== 8'h00 && n < 60);
    if (n >= 60) hang;
  endtask
  task automatic wait_irq(output int t);
    int n;
    // request trails the flag by one cycle
    repeat (2) @(negedge clk_in);
    n = 0;
    while (pit_irq_out !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 2000) hang;
    t = cyc;
  endtask
  task automatic period(output int per);
    int t0, t1;
    wait_irq(t0);
    rd(8'h4c, 8'h01);
    wr(8'h4c, 8'h01);
    wait_irq(t0);
    wr(8'h4c, 8'h01);
    wait_irq(t1);
    wr(8'h4c, 8'h01);
    rd(8'h4c, 8'h00);
    per = t1 - t0;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(rst_addr[i], 8'h00);
    rd(8'hfc, 8'h00);
    chk({16'h0, compare_value_out}, {16'h0, CMP_RST});
    repeat (4) begin
      v = $random(seed);
      wr(8'h30, v[7:0]);
      wr(8'h31, ~v[7:0]);
      wr(8'h34, v[15:8]);
      repeat (2) @(negedge clk_in);
      chk({16'h0, compare_value_out}, {16'h0, v[15:0]});
      rd(8'h31, 8'h00);
      rd(8'h30, v[7:0]);
      rd(8'h34, v[15:8]);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h40, ctrl_val[i]);
      rd(8'h40, ctrl_val[i] & CTRL_WMASK);
      rd(8'h44, 8'h01);
      sync_wait;
      wr(8'h4c, 8'h01);
      repeat (300) @(negedge clk_in);
      rd(8'h4c, 8'h00);
    end
    wr(8'h48, 8'h01);
    wr(8'h64, 8'h01);
    for (s = 0; s < 4; s++) begin
      c = 1 + {$random(seed)} % 3;
      wr(8'h1c, s[7:0]);
      wr(8'h40, {1'b0, c[3:0], 3'h1});
      sync_wait;
      period(p);
      chk(p, exp_period(s, c));
    end
    wait_irq(p);
    repeat (2) @(negedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    rd(8'h60, 8'h03);
    repeat (2) @(negedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    wr(8'h64, 8'h00);
    wr(8'h48, 8'h00);
    repeat (300) @(negedge clk_in);
    chk({30'h0, pit_irq_out, irq_out}, 32'h0);
    rd(8'h4c, 8'h01);
    wr(8'h48, 8'h01);
    repeat (2) @(negedge clk_in);
    chk({31'h0, pit_irq_out}, 32'h1);
    wr(8'h40, 8'h00);
    sync_wait;
    wr(8'h1c, 8'h00);
    wr(8'h40, 8'h09);
    sync_wait;
    cpu_halted_in <= 1'b1;
    wr(8'h4c, 8'h01);
    repeat (200) @(negedge clk_in);
    rd(8'h4c, 8'h00);
    wr(8'h54, 8'h01);
    rd(8'h54, 8'h01);
    wait_irq(p);
    cpu_halted_in <= 1'b0;
    summarize;
  end
endmodule
